// ---- adc_seq_pkg.sv ----
// Constants and types for the converter conversion sequencer
package adc_seq_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [2:0] OFS_STATUS_CONTROL = 3'h0;
	localparam logic [2:0] OFS_RESULT_HIGH    = 3'h1;
	localparam logic [2:0] OFS_RESULT_LOW     = 3'h2;
	localparam logic [2:0] OFS_CONFIG         = 3'h3;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int DONE_BIT   = 7;
	localparam int IRQEN_BIT  = 6;
	localparam int CONT_BIT   = 5;
	localparam int ASYNC_BIT  = 0;
	localparam int EXTM_BIT   = 1;
	localparam logic [4:0] CHANNEL_OFF = 5'h1F;
	localparam logic [4:0] CHANNEL_RST = 5'h1F;
	localparam logic [7:0] CONFIG_RST  = 8'h00;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam real CLK_MHZ      = 250.0;
	localparam int  CONV_CYCLES  = 21;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CONVERT,
		ST_WAIT_TRIG
	} conv_state_e;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_s;

endpackage

// ---- adc_conversion_sequencer.sv ----
// Conversion sequencer: control register, start/abort, done flag and interrupt
`timescale 1ns/100ps
module adc_conversion_sequencer import adc_seq_pkg::*; #(
	parameter int RES_W       = 10,
	parameter int CONV_CYC    = CONV_CYCLES
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic             clk_en,
	input  wire bus_req_s         bus,
	output logic      [7:0]       rdata,
	input  wire logic             wait_mode,
	input  wire logic             stop_mode,
	input  wire logic             break_active,
	input  wire logic             break_clear_enable,
	input  wire logic             external_conv_trigger,
	input  wire logic [RES_W-1:0] sample_value,
	output logic                  conv_irq,
	output logic                  converter_on
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_s1;
	logic rst_n;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function automatic logic hit(input bus_req_s b, input logic [2:0] ofs, input logic w);
		hit = (b.addr == ofs) && (w ? b.wr : b.rd);
	endfunction

	logic        conv_irq_enable;
	logic        continuous_conv_bit;
	logic [4:0]  channel_select_field;
	logic        async_clock_enable;
	logic        ext_mode;
	logic        conv_done_flag;
	logic [RES_W-1:0] result;
	conv_state_e state;
	logic [7:0]  cnt;
	logic        stop_d;

	wire trig_int     = 1'b0 & external_conv_trigger;
	wire wr_sc        = hit(bus, OFS_STATUS_CONTROL, 1'b1);
	wire wr_cfg       = hit(bus, OFS_CONFIG, 1'b1);
	wire rd_low       = hit(bus, OFS_RESULT_LOW, 1'b0);
	wire protect      = break_active && !break_clear_enable;
	wire ch_off       = (bus.wdata[4:0] == CHANNEL_OFF);
	wire stop_abort   = stop_mode && !async_clock_enable;
	wire conv_end     = (state == ST_CONVERT) && (cnt == 8'(CONV_CYC - 1)) && !stop_abort;
	wire clr_done     = (wr_sc || rd_low) && !protect;

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_irq_enable      <= 1'b0;
			continuous_conv_bit  <= 1'b0;
			channel_select_field <= CHANNEL_RST;
		end else if (clk_en && wr_sc) begin
			conv_irq_enable      <= bus.wdata[IRQEN_BIT];
			continuous_conv_bit  <= bus.wdata[CONT_BIT];
			channel_select_field <= bus.wdata[4:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			async_clock_enable <= CONFIG_RST[ASYNC_BIT];
			ext_mode           <= CONFIG_RST[EXTM_BIT];
		end else if (clk_en && wr_cfg) begin
			async_clock_enable <= bus.wdata[ASYNC_BIT];
			ext_mode           <= bus.wdata[EXTM_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stop_d <= 1'b0;
		end else if (clk_en) begin
			stop_d <= stop_abort;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			cnt   <= 8'h00;
		end else if (clk_en) begin
			if (wr_sc || wr_cfg) begin
				cnt <= 8'h00;
				if (wr_sc && !ch_off) begin
					state <= ST_CONVERT;
				end else begin
					state <= ST_IDLE;
				end
			end else if (stop_abort) begin
				state <= ST_IDLE;
				cnt   <= 8'h00;
			end else begin
				case (state)
					ST_IDLE: begin
						if (stop_mode && ext_mode && async_clock_enable
							&& channel_select_field != CHANNEL_OFF) begin
							state <= ST_WAIT_TRIG;
						end
					end
					ST_CONVERT: begin
						// Wait mode has no effect here
						if (conv_end) begin
							cnt <= 8'h00;
							if (continuous_conv_bit && channel_select_field != CHANNEL_OFF) begin
								state <= ST_CONVERT;
							end else begin
								state <= ST_IDLE;
							end
						end else begin
							cnt <= cnt + 8'h01;
						end
					end
					ST_WAIT_TRIG: begin
						if (!stop_mode) begin
							state <= ST_IDLE;
						end else if (trig_int) begin
							state <= ST_CONVERT;
						end
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Result, done flag, interrupt
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			result <= '0;
		end else if (clk_en && conv_end) begin
			result <= sample_value;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_done_flag <= 1'b0;
			conv_irq       <= 1'b0;
		end else if (clk_en) begin
			if (conv_end) begin
				conv_done_flag <= 1'b1;
				conv_irq       <= conv_irq_enable;
			end else begin
				if (clr_done) begin
					conv_done_flag <= 1'b0;
				end
				if (clr_done || (wr_sc && !protect)) begin
					conv_irq <= 1'b0;
				end else if (wr_sc && bus.wdata[IRQEN_BIT] == 1'b0) begin
					conv_irq <= conv_irq;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			converter_on <= 1'b0;
		end else if (clk_en) begin
			converter_on <= (state == ST_CONVERT);
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	logic [15:0] res16;
	assign res16 = 16'(result);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (clk_en) begin
			rdata <= 8'h00;
			if (bus.rd) begin
				case (bus.addr)
					OFS_STATUS_CONTROL: rdata <= {conv_done_flag, conv_irq_enable,
						continuous_conv_bit, channel_select_field};
					OFS_RESULT_HIGH: rdata <= res16[15:8];
					OFS_RESULT_LOW:  rdata <= res16[7:0];
					OFS_CONFIG:      rdata <= {6'h00, ext_mode, async_clock_enable};
					default:         rdata <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_done_on_end: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && conv_end |=> conv_done_flag)
		else $error("done flag not set at conversion end");
	a_irq_with_done: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && conv_end && conv_irq_enable |=> conv_irq && conv_done_flag)
		else $error("interrupt not raised with done flag");
	a_stop_aborts: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && stop_abort && !wr_sc && !wr_cfg |=> state == ST_IDLE)
		else $error("stop did not abort conversion");
	a_result_holds: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && !conv_end |=> $stable(result))
		else $error("result changed without completion");
	a_write_starts: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && wr_sc && !ch_off |=> state == ST_CONVERT && cnt == 8'h00)
		else $error("control write did not restart conversion");
	a_off_no_start: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && wr_sc && ch_off |=> state == ST_IDLE)
		else $error("all-ones channel started a conversion");
	a_protect_hold: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && protect && !conv_end |=> $stable(conv_done_flag))
		else $error("status changed in protected break");
	a_clear_done: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && clr_done && !conv_end |=> !conv_done_flag && !conv_irq)
		else $error("done flag not cleared");
	a_single_idle: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && conv_end && !continuous_conv_bit && !wr_sc && !wr_cfg
		|=> state == ST_IDLE)
		else $error("single mode did not return to idle");
	a_irq_needs_enable: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && conv_end && !conv_irq_enable |=> !conv_irq)
		else $error("interrupt raised while disabled");
	a_irq_has_done: assert property (@(posedge clk) disable iff (!rst_n)
		conv_irq |-> conv_done_flag)
		else $error("interrupt pending without done flag");
	a_irq_withdrawn: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && wr_sc && !protect && !conv_end |=> !conv_irq)
		else $error("interrupt not withdrawn by control write");
	a_wait_ignored: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && wait_mode && state == ST_CONVERT && !conv_end && !stop_abort
		&& !wr_sc && !wr_cfg |=> state == ST_CONVERT)
		else $error("wait mode disturbed a conversion");
	a_stop_resume: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && stop_d && !stop_abort && state != ST_CONVERT && !wr_sc
		|=> state != ST_CONVERT)
		else $error("conversion resumed after stop without a write");
	a_async_keeps: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && stop_mode && async_clock_enable && state == ST_CONVERT && !conv_end
		&& !wr_sc && !wr_cfg |=> state == ST_CONVERT)
		else $error("stop with async clock stopped a conversion");
	a_trig_wait: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && state == ST_IDLE && stop_mode && ext_mode && async_clock_enable
		&& channel_select_field != CHANNEL_OFF && !wr_sc && !wr_cfg
		|=> state == ST_WAIT_TRIG)
		else $error("external mode did not wait for trigger in stop");
	a_trig_tied: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && state == ST_WAIT_TRIG && !wr_sc |=> state != ST_CONVERT)
		else $error("tied trigger started a conversion");
	a_break_clear: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && break_active && break_clear_enable && rd_low && !conv_end |=> !conv_done_flag)
		else $error("unprotected break did not clear done flag");
	a_protect_irq: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && protect && !conv_end |=> $stable(conv_irq))
		else $error("interrupt changed in protected break");
	a_protect_read: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && protect && rd_low && conv_done_flag |=> conv_done_flag)
		else $error("low result read cleared done in protected break");
	a_second_step: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && !break_active && rd_low && !conv_end |=> !conv_done_flag)
		else $error("low result read after break did not clear done");
	a_cont_repeat: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && conv_end && continuous_conv_bit && channel_select_field != CHANNEL_OFF
		&& !wr_sc && !wr_cfg |=> state == ST_CONVERT && cnt == 8'h00)
		else $error("continuous mode did not start the next conversion");
	a_result_loads: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && conv_end |=> result == $past(sample_value))
		else $error("result not loaded at conversion end");
	a_cnt_bound: assert property (@(posedge clk) disable iff (!rst_n)
		state == ST_CONVERT |-> cnt <= 8'(CONV_CYC - 1))
		else $error("conversion counter ran past its end");
	a_on_follows: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && state == ST_CONVERT |=> converter_on)
		else $error("converter not on while converting");
	a_off_follows: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && state != ST_CONVERT |=> !converter_on)
		else $error("converter on while not converting");
	a_off_stays: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && state == ST_IDLE && channel_select_field == CHANNEL_OFF && !wr_sc
		|=> state == ST_IDLE)
		else $error("converter left low power with channel off");
	a_reset_clears: assert property (@(posedge clk)
		!rst_n |-> !conv_irq && !conv_done_flag && !conv_irq_enable && !continuous_conv_bit)
		else $error("reset left status or control bits set");

endmodule

// ---- cpu_bus_model.sv ----
// CPU side model: register bus cycles and expected read data
`timescale 1ns/100ps
module cpu_bus_model import adc_seq_pkg::*; (
	input  wire logic clk,
	output bus_req_s  bus
);
	logic [7:0] exp_q[$];

	initial bus = '0;

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr    <= 1'b0;
		bus.wdata <= ~d;
		@(posedge clk);
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bus.addr <= a;
		bus.rd   <= 1'b1;
		@(posedge clk);
		bus.rd   <= 1'b0;
		bus.addr <= ~a;
		@(posedge clk);
	endtask
endmodule

// ---- adc_conversion_sequencer_test.sv ----
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
`define CHK(a, b) check(16'(a), 16'(b))
module adc_conversion_sequencer_test import adc_seq_pkg::*;;
	localparam int CV = 4;
	logic       clk = 1'b0;
	logic       arst_n = 1'b0;
	logic       wait_mode, stop_mode, break_active, break_clear_enable, ext_trig;
	logic [9:0] sample_value;
	bus_req_s   bus;
	logic [7:0] rdata;
	logic       conv_irq, converter_on;
	logic       pend = 1'b0;
	logic [4:0] ch;
	int         num_errors = 0, n_checks = 0, seed = 78339, cycles = 0;

	initial forever #2 clk = ~clk;

	cpu_bus_model u_cpu (.clk(clk), .bus(bus));

	adc_conversion_sequencer #(.RES_W(10), .CONV_CYC(CV)) DUT (
		.clk(clk), .arst_n(arst_n), .clk_en(1'b1), .bus(bus), .rdata(rdata),
		.wait_mode(wait_mode), .stop_mode(stop_mode), .break_active(break_active),
		.break_clear_enable(break_clear_enable), .external_conv_trigger(ext_trig),
		.sample_value(sample_value), .conv_irq(conv_irq), .converter_on(converter_on));

	function automatic void check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endfunction

	task automatic give_verdict();
		$display("Checks %0d, errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic conv(input logic [7:0] c);
		u_cpu.wr(OFS_STATUS_CONTROL, c);
		repeat (CV + 4) @(posedge clk);
	endtask

	// Read data stands only in the cycle after the strobe
	always @(posedge clk) begin
		if (pend)
			`CHK(rdata, u_cpu.exp_q.pop_front());
		pend <= bus.rd;
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			give_verdict();
		end
	end

	initial begin
		{wait_mode, stop_mode, break_active, break_clear_enable, ext_trig} = '0;
		sample_value = 10'h000;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		u_cpu.rd(OFS_STATUS_CONTROL, {3'b000, CHANNEL_RST});
		u_cpu.rd(OFS_CONFIG, CONFIG_RST);
		u_cpu.rd(3'h5, 8'h00);
		`CHK(conv_irq, 1'b0);
		$display("Test reset values done");
		for (int i = 0; i < 4; i++) begin
			ch = 5'($unsigned($random(seed)) % 31);
			sample_value <= 10'($random(seed));
			wait_mode <= i[1]; // Continuous mode left off before wait
			conv({1'b0, i[0], 1'b0, ch});
			`CHK(conv_irq, i[0]);
			`CHK(converter_on, 1'b0);
			u_cpu.rd(OFS_STATUS_CONTROL, {1'b1, i[0], 1'b0, ch});
			u_cpu.rd(OFS_RESULT_HIGH, {6'h00, sample_value[9:8]});
			u_cpu.rd(OFS_RESULT_LOW, sample_value[7:0]);
			u_cpu.rd(OFS_STATUS_CONTROL, {1'b0, i[0], 1'b0, ch});
			`CHK(conv_irq, 1'b0);
		end
		wait_mode <= 1'b0;
		conv(8'hDF);
		`CHK(converter_on, 1'b0);
		u_cpu.rd(OFS_STATUS_CONTROL, 8'h5F);
		$display("Test single conversions done");
		sample_value <= ~sample_value;
		u_cpu.wr(OFS_STATUS_CONTROL, {3'b010, ch});
		stop_mode <= 1'b1; // Continuous mode left off before stop
		repeat (CV + 4) @(posedge clk);
		`CHK(converter_on, 1'b0);
		stop_mode <= 1'b0;
		repeat (CV + 4) @(posedge clk);
		u_cpu.rd(OFS_STATUS_CONTROL, {3'b010, ch});
		u_cpu.rd(OFS_RESULT_LOW, ~sample_value[7:0]);
		$display("Test stop abort done");
		u_cpu.wr(OFS_CONFIG, 8'h01);
		stop_mode <= 1'b1;
		conv({3'b010, ch});
		`CHK(conv_irq, 1'b1);
		u_cpu.rd(OFS_RESULT_LOW, sample_value[7:0]);
		u_cpu.wr(OFS_CONFIG, 8'h03);
		ext_trig <= 1'b1;
		repeat (CV + 4) @(posedge clk);
		`CHK(converter_on, 1'b0);
		`CHK(conv_irq, 1'b0);
		{stop_mode, ext_trig} <= 2'b00;
		u_cpu.wr(OFS_CONFIG, 8'h00);
		$display("Test async stop done");
		conv({3'b010, ch});
		break_active <= 1'b1;
		u_cpu.rd(OFS_RESULT_LOW, sample_value[7:0]);
		u_cpu.rd(OFS_STATUS_CONTROL, {3'b110, ch});
		`CHK(conv_irq, 1'b1);
		break_active <= 1'b0;
		u_cpu.rd(OFS_RESULT_LOW, sample_value[7:0]);
		u_cpu.rd(OFS_STATUS_CONTROL, {3'b010, ch});
		conv({3'b010, ch});
		{break_active, break_clear_enable} <= 2'b11;
		u_cpu.rd(OFS_RESULT_LOW, sample_value[7:0]);
		{break_active, break_clear_enable} <= 2'b00;
		u_cpu.rd(OFS_STATUS_CONTROL, {3'b010, ch});
		$display("Test break done");
		u_cpu.wr(OFS_STATUS_CONTROL, {3'b001, ch});
		sample_value <= 10'($random(seed));
		repeat (3 * CV + 8) @(posedge clk);
		`CHK(converter_on, 1'b1);
		u_cpu.rd(OFS_RESULT_HIGH, {6'h00, sample_value[9:8]});
		u_cpu.rd(OFS_RESULT_LOW, sample_value[7:0]);
		conv(8'h1F);
		`CHK(converter_on, 1'b0);
		$display("Test continuous done");
		u_cpu.wr(OFS_STATUS_CONTROL, {3'b011, ch});
		repeat (2 * CV + 4) @(posedge clk);
		`CHK(conv_irq, 1'b1);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK(conv_irq, 1'b0);
		`CHK(converter_on, 1'b0);
		u_cpu.rd(OFS_STATUS_CONTROL, {3'b000, CHANNEL_RST});
		$display("Test mid-run reset done");
		@(posedge clk);
		give_verdict();
	end
endmodule
